// *** verilog/lcdc_command_decoder.sv ***
// Purpose: command interpreter and display ram of a dot-matrix lcd controller
// Assumes: single clock aclk (10 MHz), synchronous active-low aresetn, axi4-lite host
// Notes: command port (select low) at CMD, display data (select high) at DATA
`timescale 1ns/1ps
`default_nettype none
`include "lcdc_params.svh"

module lcdc_command_decoder #(
  parameter int COLUMNS = `LCDC_COLUMNS,
  parameter int PAGES = `LCDC_PAGES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic panel_on,
  output logic [5:0] start_line,
  output logic seg_reverse,
  output logic pixel_invert,
  output logic all_pixels_on,
  output logic com_reverse,
  output logic lcd_bias,
  output logic [2:0] power_ctl,
  output logic [2:0] regulator_ratio,
  output logic [5:0] contrast,
  output logic indicator_on,
  output logic [1:0] indicator_mode,
  output logic osc_sel,
  output logic partial_mode,
  output logic [2:0] partial_duty,
  output logic [2:0] partial_bias,
  output logic [5:0] partial_start,
  output logic nline_active,
  output logic [4:0] nline_count,
  output logic [3:0] dcdc_div,
  output logic dcdc_clk_en,
  output logic test_mode,
  output logic sleep_mode,
  output logic standby_mode
);

  localparam int RAM_WORDS = COLUMNS * PAGES;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic aw_held;
    logic [7:0] awaddr;
    logic w_held;
    logic [7:0] wbyte;
    logic wlane;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    lcdc_pkg::lcdc_pend_e pend;
    logic panel_on;
    logic [5:0] start_line;
    logic [3:0] page;
    logic [7:0] column;
    logic seg_reverse;
    logic invert;
    logic all_on;
    logic com_reverse;
    logic bias;
    logic rmw;
    logic [2:0] power;
    logic [2:0] ratio;
    logic [5:0] contrast;
    logic indicator;
    logic [1:0] ind_mode;
    logic osc_sel;
    logic partial;
    logic [2:0] pduty;
    logic [2:0] pbias;
    logic [5:0] pstart;
    logic nline_on;
    logic [4:0] nline;
    logic [3:0] div;
    logic [4:0] div_cnt;
    logic div_pulse;
    logic test;
  } lcdc_state_s;

  lcdc_state_s state_reg;
  lcdc_state_s state_next;
  logic [7:0] ram [RAM_WORDS];
  logic ram_we;
  logic [`LCDC_RAM_AW-1:0] ram_idx;
  logic addr_ok;
  logic [7:0] ram_q;
  logic wr_exec;
  logic ar_take;
  logic [7:0] b;
  logic [7:0] status_byte;
  logic power_save;
  logic [4:0] div_last;

  function automatic logic [7:0] col_step(input logic [7:0] col);
    // the counter stops on the last column instead of wrapping
    if (32'(col) >= COLUMNS - 1) begin
      return col;
    end
    return col + 8'h01;
  endfunction : col_step

  // ------------------------------------------------------------
  // display ram access at the current page and column
  // ------------------------------------------------------------
  assign ram_idx = `LCDC_RAM_AW'(32'(state_reg.page) * COLUMNS + 32'(state_reg.column));
  assign addr_ok = (32'(state_reg.page) < PAGES) && (32'(state_reg.column) < COLUMNS);
  assign ram_q = addr_ok ? ram[ram_idx] : 8'h00;

  always_ff @(posedge aclk) begin
    if (ram_we) begin
      ram[ram_idx] <= state_reg.wbyte;
    end
  end

  // ------------------------------------------------------------
  // handshakes: reads wait while a write is ready to execute
  // ------------------------------------------------------------
  assign wr_exec = state_reg.aw_held && state_reg.w_held && !state_reg.bvalid;
  assign s_axi_awready = !state_reg.aw_held && !state_reg.bvalid;
  assign s_axi_wready = !state_reg.w_held && !state_reg.bvalid;
  assign s_axi_arready = !state_reg.rvalid && !(state_reg.aw_held && state_reg.w_held);
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign b = state_reg.wbyte;

  // display off plus all pixels on is the power save compound
  assign power_save = !state_reg.panel_on && state_reg.all_on;
  // busy and reset flags never show: commands complete in one clock
  assign status_byte = {1'b0, state_reg.seg_reverse, !state_reg.panel_on, 1'b0, 4'h0};
  assign div_last = {state_reg.div, 1'b0} - 5'h01;

  always_comb begin
    state_next = state_reg;
    ram_we = 1'b0;

    if (s_axi_awvalid && s_axi_awready) begin
      state_next.aw_held = 1'b1;
      state_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      state_next.w_held = 1'b1;
      state_next.wbyte = s_axi_wdata[7:0];
      state_next.wlane = s_axi_wstrb[0];
    end
    if (state_reg.bvalid && s_axi_bready) begin
      state_next.bvalid = 1'b0;
    end
    if (state_reg.rvalid && s_axi_rready) begin
      state_next.rvalid = 1'b0;
    end

    // ------------------------------------------------------------
    // write execution
    // ------------------------------------------------------------
    if (wr_exec) begin
      state_next.aw_held = 1'b0;
      state_next.w_held = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp = `LCDC_RESP_OKAY;
      if (state_reg.awaddr == `LCDC_OFS_DATA) begin
        if (state_reg.wlane) begin
          ram_we = addr_ok;
          state_next.column = col_step(state_reg.column);
        end
      end else if (state_reg.awaddr == `LCDC_OFS_CMD) begin
        if (!state_reg.wlane) begin
          state_next.pend = state_reg.pend;
        end else if (state_reg.pend != lcdc_pkg::PEND_NONE) begin
          state_next.pend = lcdc_pkg::PEND_NONE;
          unique case (state_reg.pend)
            lcdc_pkg::PEND_CONTRAST: state_next.contrast = b[5:0];
            lcdc_pkg::PEND_INDICATOR: state_next.ind_mode = b[1:0];
            lcdc_pkg::PEND_PART_START: state_next.pstart = b[5:0];
            lcdc_pkg::PEND_NLINE: begin
              state_next.nline = b[4:0];
              state_next.nline_on = 1'b1;
            end
            lcdc_pkg::PEND_DCDC: begin
              state_next.div = b[3:0];
              state_next.div_cnt = 5'h00;
            end
            default: state_next.pend = lcdc_pkg::PEND_NONE;
          endcase
        end else if (state_reg.test) begin
          // only the exit code or a soft reset leaves test mode
          if (b == `LCDC_C_TEST_END || b == `LCDC_C_SOFT_RESET) begin
            state_next.test = 1'b0;
          end
        end else begin
          casez (b)
            8'b01??_????: state_next.start_line = b[5:0];
            8'b0001_????: state_next.column = {b[3:0], state_reg.column[3:0]};
            8'b0000_????: state_next.column = {state_reg.column[7:4], b[3:0]};
            8'b1011_????: begin
              if (b[3:0] <= `LCDC_LAST_PAGE) begin
                state_next.page = b[3:0];
              end
            end
            8'b1100_????: state_next.com_reverse = b[3];
            8'b0010_1???: state_next.power = b[2:0];
            8'b0010_0???: state_next.ratio = b[2:0];
            8'b0011_0???: begin
              if (state_reg.partial && b[2:0] <= `LCDC_MAX_DUTY_CODE) begin
                state_next.pduty = b[2:0];
              end
            end
            8'b0011_1???: begin
              if (state_reg.partial && b[2:0] <= `LCDC_MAX_BIAS_CODE) begin
                state_next.pbias = b[2:0];
              end
            end
            {`LCDC_C_PANEL, 1'b?}: state_next.panel_on = b[0];
            {`LCDC_C_SEGDIR, 1'b?}: state_next.seg_reverse = b[0];
            {`LCDC_C_BIAS, 1'b?}: state_next.bias = b[0];
            {`LCDC_C_ALLON, 1'b?}: state_next.all_on = b[0];
            {`LCDC_C_INVERT, 1'b?}: state_next.invert = b[0];
            {`LCDC_C_INDIC, 1'b?}: begin
              state_next.indicator = b[0];
              state_next.pend = lcdc_pkg::PEND_INDICATOR;
            end
            {`LCDC_C_OSC, 1'b?}: state_next.osc_sel = b[0];
            `LCDC_C_CONTRAST: state_next.pend = lcdc_pkg::PEND_CONTRAST;
            `LCDC_C_PART_OFF: state_next.partial = 1'b0;
            `LCDC_C_PART_ON: state_next.partial = 1'b1;
            `LCDC_C_NLINE_REL: state_next.nline_on = 1'b0;
            `LCDC_C_NLINE: state_next.pend = lcdc_pkg::PEND_NLINE;
            `LCDC_C_PSL: state_next.pend = lcdc_pkg::PEND_PART_START;
            `LCDC_C_DCDC: state_next.pend = lcdc_pkg::PEND_DCDC;
            `LCDC_C_RMW: state_next.rmw = 1'b1;
            `LCDC_C_RMW_END: state_next.rmw = 1'b0;
            `LCDC_C_SOFT_RESET: begin
              state_next.start_line = 6'h00;
              state_next.page = 4'h0;
              state_next.column = 8'h00;
              state_next.rmw = 1'b0;
              state_next.com_reverse = 1'b0;
              state_next.power = 3'h0;
              state_next.contrast = `LCDC_RST_CONTRAST;
            end
            `LCDC_C_TEST_END: state_next.test = 1'b0;
            {`LCDC_C_TEST_NIB, 4'b????}: state_next.test = 1'b1;
            default: state_next.test = state_reg.test;
          endcase
        end
      end else begin
        state_next.bresp = `LCDC_RESP_SLVERR;
      end
    end

    // ------------------------------------------------------------
    // read execution
    // ------------------------------------------------------------
    if (ar_take) begin
      state_next.rvalid = 1'b1;
      state_next.rresp = `LCDC_RESP_OKAY;
      state_next.rdata = 32'h0000_0000;
      unique case (s_axi_araddr)
        `LCDC_OFS_CMD: state_next.rdata = {24'h00_0000, status_byte};
        `LCDC_OFS_DATA: begin
          state_next.rdata = {24'h00_0000, ram_q};
          if (!state_reg.rmw) begin
            state_next.column = col_step(state_reg.column);
          end
        end
        `LCDC_OFS_MODE: begin
          state_next.rdata = {13'h0000, state_reg.pend, 2'h0,
                              sleep_mode, standby_mode, state_reg.test, state_reg.nline_on,
                              state_reg.indicator, state_reg.partial, state_reg.osc_sel,
                              state_reg.bias, state_reg.rmw, state_reg.com_reverse,
                              state_reg.all_on, state_reg.invert, state_reg.seg_reverse,
                              state_reg.panel_on};
        end
        `LCDC_OFS_ADDR: begin
          state_next.rdata = {8'h00, state_reg.column, 4'h0, state_reg.page,
                              2'h0, state_reg.start_line};
        end
        `LCDC_OFS_LEVEL: begin
          state_next.rdata = {1'b0, state_reg.pbias, 1'b0, state_reg.pduty,
                              2'h0, state_reg.ind_mode, state_reg.div, 1'b0, state_reg.ratio,
                              1'b0, state_reg.power, 2'h0, state_reg.contrast};
        end
        `LCDC_OFS_LINES: begin
          state_next.rdata = {19'h0_0000, state_reg.nline, 2'h0, state_reg.pstart};
        end
        default: state_next.rresp = `LCDC_RESP_SLVERR;
      endcase
    end

    // ------------------------------------------------------------
    // charge-pump clock enable, period 2n clocks, every clock at n = 0
    // ------------------------------------------------------------
    state_next.div_pulse = 1'b0;
    if (state_reg.div == 4'h0) begin
      state_next.div_pulse = 1'b1;
      state_next.div_cnt = 5'h00;
    end else if (state_reg.div_cnt >= div_last) begin
      state_next.div_pulse = 1'b1;
      state_next.div_cnt = 5'h00;
    end else begin
      state_next.div_cnt = state_reg.div_cnt + 5'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= '0;
      state_reg.pend <= lcdc_pkg::PEND_NONE;
      state_reg.div <= `LCDC_RST_DCDC_DIV;
      state_reg.contrast <= `LCDC_RST_CONTRAST;
      state_reg.nline <= `LCDC_RST_NLINE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign s_axi_bvalid = state_reg.bvalid;
  assign s_axi_bresp = state_reg.bresp;
  assign s_axi_rvalid = state_reg.rvalid;
  assign s_axi_rdata = state_reg.rdata;
  assign s_axi_rresp = state_reg.rresp;
  assign panel_on = state_reg.panel_on;
  assign start_line = state_reg.start_line;
  assign seg_reverse = state_reg.seg_reverse;
  assign pixel_invert = state_reg.invert;
  assign all_pixels_on = state_reg.all_on;
  assign com_reverse = state_reg.com_reverse;
  assign lcd_bias = state_reg.bias;
  assign power_ctl = state_reg.power;
  assign regulator_ratio = state_reg.ratio;
  assign contrast = state_reg.contrast;
  assign indicator_on = state_reg.indicator;
  assign indicator_mode = state_reg.ind_mode;
  assign osc_sel = state_reg.osc_sel;
  assign partial_mode = state_reg.partial;
  assign partial_duty = state_reg.pduty;
  assign partial_bias = state_reg.pbias;
  assign partial_start = state_reg.pstart;
  // short partial duties (codes 0 and 1) fall back to frame inversion
  assign nline_active = state_reg.nline_on && !(state_reg.partial && state_reg.pduty < 3'h2);
  assign nline_count = state_reg.nline;
  assign dcdc_div = state_reg.div;
  assign dcdc_clk_en = state_reg.div_pulse;
  assign test_mode = state_reg.test;
  assign sleep_mode = power_save && !state_reg.indicator;
  assign standby_mode = power_save && state_reg.indicator;

endmodule : lcdc_command_decoder

`default_nettype wire

// *** verilog/lcdc_params.svh ***
// Purpose: constants of the lcd command decoder: offsets, fields, codes, reset values
// Assumes: included by bare name from the package and the decoder
// Notes: definitions only
`ifndef LCDC_PARAMS_SVH
`define LCDC_PARAMS_SVH

// ------------------------------------------------------------
// register offsets (byte addresses on the axi4-lite bus)
// ------------------------------------------------------------
`define LCDC_OFS_CMD 8'h00
`define LCDC_OFS_DATA 8'h04
`define LCDC_OFS_MODE 8'h08
`define LCDC_OFS_ADDR 8'h0C
`define LCDC_OFS_LEVEL 8'h10
`define LCDC_OFS_LINES 8'h14

// ------------------------------------------------------------
// geometry
// ------------------------------------------------------------
`define LCDC_COLUMNS 132
`define LCDC_PAGES 9
`define LCDC_RAM_AW 11
`define LCDC_LAST_PAGE 4'h8

// ------------------------------------------------------------
// command codes
// ------------------------------------------------------------
`define LCDC_C_CONTRAST 8'h81
`define LCDC_C_PART_OFF 8'h82
`define LCDC_C_PART_ON 8'h83
`define LCDC_C_NLINE_REL 8'h84
`define LCDC_C_NLINE 8'h85
`define LCDC_C_SEGDIR 7'b1010_000
`define LCDC_C_BIAS 7'b1010_001
`define LCDC_C_ALLON 7'b1010_010
`define LCDC_C_INVERT 7'b1010_011
`define LCDC_C_INDIC 7'b1010_110
`define LCDC_C_PANEL 7'b1010_111
`define LCDC_C_PSL 8'hD3
`define LCDC_C_RMW 8'hE0
`define LCDC_C_SOFT_RESET 8'hE2
`define LCDC_C_NOP 8'hE3
`define LCDC_C_OSC 7'b1110_010
`define LCDC_C_DCDC 8'hE6
`define LCDC_C_RMW_END 8'hEE
`define LCDC_C_TEST_END 8'hF0
`define LCDC_C_TEST_NIB 4'hF
`define LCDC_MAX_DUTY_CODE 3'h4
`define LCDC_MAX_BIAS_CODE 3'h5

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define LCDC_RST_DCDC_DIV 4'h3
`define LCDC_RST_CONTRAST 6'h20
`define LCDC_RST_NLINE 5'h00

// ------------------------------------------------------------
// bus answers
// ------------------------------------------------------------
`define LCDC_RESP_OKAY 2'b00
`define LCDC_RESP_SLVERR 2'b10

`endif

// *** verilog/lcdc_pkg.sv ***
// Purpose: types of the lcd command decoder
// Assumes: lcdc_params.svh holds the numbers
// Notes: nothing is imported; users write lcdc_pkg::name
`include "lcdc_params.svh"

package lcdc_pkg;

  // ------------------------------------------------------------
  // which data byte the next command-port write is taken as
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    PEND_NONE,
    PEND_CONTRAST,
    PEND_INDICATOR,
    PEND_PART_START,
    PEND_NLINE,
    PEND_DCDC
  } lcdc_pend_e;

endpackage : lcdc_pkg

// *** verification/lcdc_host.sv ***
// Purpose: host processor model driving the axi4-lite register port
// Assumes: slave answers each write with bvalid and each read with rvalid
// Notes: bready and rready stay high, so an answer is taken on the edge it is seen
`timescale 1ns/1ps
`default_nettype none
module lcdc_host (
  input wire logic aclk,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  // only the low byte carries a command or pixel byte, full strobe always
  assign s_axi_wstrb = 4'hF;
  assign s_axi_bready = 1'b1;
  assign s_axi_rready = 1'b1;
  initial begin
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wvalid = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
  end
  // released payloads are inverted so a stale value is never mistaken for a live one
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~s_axi_wdata;
      end
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        break;
      end
    end
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] q, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
      end
      if (s_axi_rvalid) begin
        q = s_axi_rdata;
        r = s_axi_rresp;
        break;
      end
    end
  endtask : rd
endmodule : lcdc_host
`default_nettype wire

// *** verification/lcdc_command_decoder_sva.sv ***
// Purpose: concurrent checks on the command decoder ports
// Assumes: full-strobe writes; effects show in the cycle bvalid rises
// Notes: pairing is tracked so data bytes are not read as commands
`timescale 1ns/1ps
`default_nettype none
module lcdc_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic panel_on,
  input wire logic [5:0] start_line,
  input wire logic com_reverse,
  input wire logic [2:0] power_ctl,
  input wire logic [3:0] dcdc_div,
  input wire logic dcdc_clk_en,
  input wire logic nline_active,
  input wire logic test_mode
);
  logic [7:0] a_q, d_q, c_q;
  logic b_q, p_q, t_q;
  logic cw, ec, ed;
  assign cw = s_axi_bvalid && !b_q && a_q == 8'h00;
  assign ec = cw && !p_q && !t_q;
  assign ed = cw && p_q && c_q == 8'hE6;
  always_ff @(posedge aclk) begin
    if (s_axi_awvalid && s_axi_awready) a_q <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready) d_q <= s_axi_wdata[7:0];
    if (cw) c_q <= d_q;
    b_q <= s_axi_bvalid;
    t_q <= test_mode;
    if (!aresetn) p_q <= 1'b0;
    else if (cw) p_q <= !p_q && !t_q && (d_q inside {8'h81, 8'hAC, 8'hAD, 8'hD3, 8'h85, 8'hE6});
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  panel_follow_a: assert property (ec && d_q[7:1] == 7'h57 |-> panel_on == d_q[0])
    else $error("panel drive differs from command bit");
  start_load_a: assert property (ec && d_q[7:6] == 2'h1 |-> start_line == d_q[5:0])
    else $error("start line not loaded");
  com_dir_a: assert property (ec && d_q[7:4] == 4'hC |-> com_reverse == d_q[3])
    else $error("scan direction differs from bit 3");
  power_load_a: assert property (ec && d_q[7:3] == 5'h05 |-> power_ctl == d_q[2:0])
    else $error("power controls not loaded");
  div_data_a: assert property (ed |-> dcdc_div == d_q[3:0] && $stable(panel_on))
    else $error("division byte misread");
  nline_off_a: assert property (ec && d_q == 8'h84 |-> !nline_active)
    else $error("line inversion still active");
  pulse_single_a: assert property (dcdc_clk_en && dcdc_div != 4'h0
    |=> !dcdc_clk_en || dcdc_div != $past(dcdc_div))
    else $error("divided clock enable longer than one cycle");
  test_entry_a: assert property (ec && d_q[7:4] == 4'hF |-> test_mode == (d_q != 8'hF0))
    else $error("test mode entry wrong");
  cover property (ed);
  cover property (ec && d_q == 8'h84);
  cover property (dcdc_clk_en && dcdc_div == 4'hF);
endmodule : lcdc_sva
bind lcdc_command_decoder lcdc_sva u_lcdc_sva (
  .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .panel_on, .start_line, .com_reverse, .power_ctl,
  .dcdc_div, .dcdc_clk_en, .nline_active, .test_mode
);
`default_nettype wire

// *** verification/lcdc_tb.sv ***
// Purpose: self-checking bench for the command decoder
// Assumes: command port at 00, data at 04, readback at 08 to 14
// Notes: the division clock is timed between steady pulses, not the first after a change
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, dcdc_div;
  logic [1:0] s_axi_bresp, s_axi_rresp, indicator_mode;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic panel_on, seg_reverse, pixel_invert, all_pixels_on, com_reverse, lcd_bias;
  logic indicator_on, osc_sel, partial_mode, nline_active, dcdc_clk_en;
  logic test_mode, sleep_mode, standby_mode;
  logic [5:0] start_line, contrast, partial_start;
  logic [2:0] power_ctl, regulator_ratio, partial_duty, partial_bias;
  logic [4:0] nline_count;
  int n_fail = 0;
  int checked = 0;
  int cyc = 0;
  lcdc_command_decoder u_lcdc_command_decoder (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .panel_on, .start_line, .seg_reverse, .pixel_invert,
    .all_pixels_on, .com_reverse, .lcd_bias, .power_ctl, .regulator_ratio, .contrast,
    .indicator_on, .indicator_mode, .osc_sel, .partial_mode, .partial_duty, .partial_bias,
    .partial_start, .nline_active, .nline_count, .dcdc_div, .dcdc_clk_en, .test_mode,
    .sleep_mode, .standby_mode);
  lcdc_host u_lcdc_host (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  always #50 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      print_verdict();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic print_verdict();
    $display("checked %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  task automatic cmd(input logic [7:0] c);
    logic [1:0] r;
    u_lcdc_host.wr(8'h00, c, r);
  endtask : cmd
  task automatic wd(input logic [7:0] d);
    logic [1:0] r;
    u_lcdc_host.wr(8'h04, d, r);
  endtask : wd
  task automatic rdq(input logic [7:0] a, output logic [31:0] q);
    logic [1:0] r;
    u_lcdc_host.rd(a, q, r);
  endtask : rdq
  // write one command, then compare a masked readback field
  task automatic cr(input logic [7:0] c, input logic [7:0] a, input logic [31:0] m, e);
    logic [31:0] q;
    cmd(c);
    rdq(a, q);
    chk(q & m, e);
  endtask : cr
  task automatic t_simple();
    cr(8'hAF, 8'h08, 32'h1, 32'h1);
    cr(8'hAE, 8'h08, 32'h1, 32'h0);
    cr(8'h7F, 8'h0C, 32'h3F, 32'h3F);
    cr(8'hA1, 8'h08, 32'h2, 32'h2);
    cr(8'hA7, 8'h08, 32'h4, 32'h4);
    cr(8'hA6, 8'h08, 32'h4, 32'h0);
    cr(8'hCF, 8'h08, 32'h10, 32'h10);
    cr(8'hC7, 8'h08, 32'h10, 32'h0);
    cr(8'h2D, 8'h10, 32'h700, 32'h500);
    cr(8'h26, 8'h10, 32'h7000, 32'h6000);
    chk(regulator_ratio, 3'h6);
    cr(8'hE5, 8'h08, 32'h80, 32'h80);
    cr(8'hE4, 8'h08, 32'h80, 32'h0);
    cr(8'hA3, 8'h08, 32'h40, 32'h40);
    chk(lcd_bias, 1'h1);
    cr(8'hB8, 8'h0C, 32'hF00, 32'h800);
    cr(8'hB9, 8'h0C, 32'hF00, 32'h800);
    cmd(8'h18);
    cr(8'h03, 8'h0C, 32'hFF0000, 32'h830000);
    cr(8'hE1, 8'h0C, 32'hFFFFFF, 32'h83083F);
  endtask : t_simple
  task automatic t_pairs();
    cmd(8'hE6);
    cr(8'hAF, 8'h10, 32'hF0000, 32'hF0000);
    chk(panel_on, 1'h0);
    cmd(8'h81);
    cmd(8'hE5);
    chk({osc_sel, contrast}, 7'h25);
    cmd(8'hAD);
    cmd(8'h02);
    chk({indicator_on, indicator_mode}, 3'h6);
    cmd(8'h85);
    cmd(8'h1F);
    chk({nline_active, nline_count}, 6'h3F);
    cr(8'h84, 8'h08, 32'h400, 32'h0);
    cmd(8'hD3);
    wd(8'h11);
    cmd(8'h3F);
    chk(partial_start, 6'h3F);
  endtask : t_pairs
  task automatic t_div();
    logic [3:0] n [4] = '{4'h0, 4'h1, 4'hF, 4'h3};
    int k;
    foreach (n[i]) begin
      cmd(8'hE6);
      cmd({4'hA, n[i]});
      chk(dcdc_div, n[i]);
      repeat (2) @(posedge aclk iff dcdc_clk_en);
      k = 0;
      do begin
        @(posedge aclk);
        k++;
      end while (!dcdc_clk_en);
      chk(k, n[i] == 4'h0 ? 32'h1 : 32'(n[i]) * 2);
    end
  endtask : t_div
  task automatic t_modes();
    logic [31:0] q;
    cr(8'h33, 8'h10, 32'h7000000, 32'h0);
    cr(8'h83, 8'h08, 32'h100, 32'h100);
    cr(8'h33, 8'h10, 32'h7000000, 32'h3000000);
    cr(8'h3A, 8'h10, 32'h70000000, 32'h20000000);
    chk({partial_mode, partial_duty, partial_bias}, 7'h5A);
    cr(8'h82, 8'h08, 32'h100, 32'h0);
    cr(8'hF5, 8'h08, 32'h800, 32'h800);
    cr(8'hAF, 8'h08, 32'h801, 32'h800);
    cr(8'hF0, 8'h08, 32'h800, 32'h0);
    cr(8'hA5, 8'h08, 32'h3009, 32'h1008);
    cmd(8'hAC);
    cr(8'h00, 8'h08, 32'h3000, 32'h2000);
    chk({sleep_mode, standby_mode, all_pixels_on, pixel_invert, seg_reverse}, 5'h15);
    rdq(8'h00, q);
    chk(q[5:0], 6'h20);
  endtask : t_modes
  task automatic t_ram();
    logic [31:0] q;
    logic [1:0] r;
    cmd(8'hB2);
    cmd(8'h10);
    cmd(8'h05);
    wd(8'hAA);
    wd(8'h55);
    cmd(8'h05);
    rdq(8'h04, q);
    chk(q, 32'hAA);
    cmd(8'hE0);
    rdq(8'h04, q);
    chk(q, 32'h55);
    wd(8'h3C);
    cmd(8'hEE);
    cmd(8'h06);
    rdq(8'h04, q);
    chk(q, 32'h3C);
    u_lcdc_host.wr(8'h20, 8'h00, r);
    chk(r, 2'h2);
    u_lcdc_host.rd(8'h20, q, r);
    chk(r, 2'h2);
    // soft reset clears the address pointers and restores the contrast default
    cr(8'hE2, 8'h0C, 32'hFFFFFF, 32'h0);
    chk(contrast, 6'h20);
  endtask : t_ram
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({dcdc_div, contrast}, 10'h0E0);
    t_simple();
    t_pairs();
    t_div();
    t_modes();
    t_ram();
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
